// ===== src/gpt_timer.sv
// General-purpose timer with capture, compare, PWM and pulse accumulator
//
// Behaviour
// [R1] Pins synchronised and filtered before any use
// [R2] Event mode: leading edge counts, sets flag
// [R3] Pulse count wrap sets overflow flag
// [R4] Gated mode counts at clk/4 while active
// [R5] Gated mode flag set at gate end
// [R6] Free-running counter advances at clk/4
// [R7] Overflow-gated mode counts on wrap while active
// [R8] PWM pin high on counter rollover, unless duty is zero
// [R9] PWM pin low when counter equals duty
// [R10] Compare match sets flag, then pin action
// [R11] Capture edge latches count, sets flag together
// [R12] Driven pin level feeds capture conditioning
// [R13] Source holds capture pulses two clocks
// [R14] Flags stay set until software clears
`timescale 1ns/1ps
`include "gpt_params.svh"

// ****************************************************************
// Input conditioner: two-flop synchroniser and two-sample filter
// ****************************************************************
module gpt_cond (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Raw level and conditioned level
    input  wire logic raw,
    output logic      filt
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic filt_ff;

    // Synchroniser, then filter on two agreeing samples
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1_ff   <= 1'b0;
            s2_ff   <= 1'b0;
            s3_ff   <= 1'b0;
            filt_ff <= 1'b0;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin // [R1]
                filt_ff <= s2_ff;
            end
        end
    end
    assign filt = filt_ff;
endmodule : gpt_cond

// ****************************************************************
// Timer top
// ****************************************************************
module gpt_timer
    import gpt_pkg::*;
(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // Capture pins, two-way
    input  wire logic [`GPT_NCAP-1:0]       cap_pin_in,
    output logic      [`GPT_NCAP-1:0]       cap_pin_out,
    output logic      [`GPT_NCAP-1:0]       cap_pin_oe,
    input  wire gpt_gpo_s                   gpo_req,
    input  wire gpt_edge_e [`GPT_NCAP-1:0]  cap_edge,
    output logic [`GPT_NCAP-1:0][`GPT_CNT_W-1:0] cap_value,
    // Pulse accumulator
    input  wire logic                       pa_pin_in,
    input  wire logic                       pa_enable,
    input  wire logic                       pa_active_high,
    input  wire gpt_pa_mode_e               pa_mode,
    output logic      [`GPT_PA_W-1:0]       pulse_count,
    // Output compare
    input  wire logic [`GPT_CNT_W-1:0]      cmp_value,
    input  wire gpt_oc_act_e                cmp_action,
    output logic                            cmp_pin,
    // PWM
    input  wire logic [`GPT_NPWM-1:0][`GPT_PWM_W-1:0] pwm_duty,
    output logic      [`GPT_NPWM-1:0]       pwm_pin,
    // Counter and flags
    output logic      [`GPT_CNT_W-1:0]      free_running_count,
    input  wire gpt_flags_s                 flag_clear,
    output gpt_flags_s                      flags
);
    logic [1:0]                   pre_ff;
    logic                         tick;
    logic                         count_overflow_event;
    logic [`GPT_CNT_W-1:0]        frc_ff;
    logic                         cnt_new_ff;
    gpt_gpo_s                     gpo_ff;
    logic [`GPT_NCAP-1:0]         cap_raw;
    logic [`GPT_NCAP-1:0]         cap_filt;
    logic [`GPT_NCAP-1:0]         cap_prev_ff;
    logic [`GPT_NCAP-1:0]         cap_evt;
    logic [`GPT_NCAP-1:0][`GPT_CNT_W-1:0] cap_val_ff;
    logic                         pa_filt;
    logic                         pa_prev_ff;
    logic                         pa_act;
    logic                         pa_act_prev;
    logic                         pa_lead;
    logic                         pa_trail;
    logic                         pa_inc;
    logic [`GPT_PA_W-1:0]         pa_cnt_ff;
    logic                         cmp_hit;
    logic                         cmp_hit_d_ff;
    gpt_oc_act_e                  cmp_act_ff;
    logic                         cmp_pin_ff;
    logic [`GPT_NPWM-1:0][`GPT_PWM_W-1:0] pwm_cnt_ff;
    logic [`GPT_NPWM-1:0]         pwm_pin_ff;
    gpt_flags_s                   flag_set;
    gpt_flags_s                   flags_ff;

    // ************************************************************
    // Prescaler and free-running counter
    // ************************************************************
    assign tick                 = (pre_ff == `GPT_PRE_LAST);
    assign count_overflow_event = tick && (frc_ff == `GPT_CNT_MAX);

    // Divide by four, advance once per tick
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pre_ff     <= 2'h0;
            frc_ff     <= 16'h0000;
            cnt_new_ff <= 1'b0;
        end else begin
            pre_ff     <= pre_ff + 2'h1;
            cnt_new_ff <= tick;
            if (tick) begin
                frc_ff <= frc_ff + 16'h0001; // [R6]
            end
        end
    end

    // ************************************************************
    // Capture pins with general-purpose drive
    // ************************************************************
    // Register the drive so pins come from flops
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            gpo_ff <= '0;
        end else begin
            gpo_ff <= gpo_req;
        end
    end

    // Driven level is what the input path sees
    assign cap_raw = (gpo_ff.oe & gpo_ff.lvl) | (~gpo_ff.oe & cap_pin_in); // [R12]

    for (genvar i = 0; i < `GPT_NCAP; i++) begin : g_cap
        gpt_cond u_cond (
            .clk     (clk),
            .reset_n (reset_n),
            .raw     (cap_raw[i]),
            .filt    (cap_filt[i])
        );
        assign cap_evt[i] =
            ((cap_edge[i] == GPT_EDGE_RISE || cap_edge[i] == GPT_EDGE_BOTH)
                && cap_filt[i] && !cap_prev_ff[i]) ||
            ((cap_edge[i] == GPT_EDGE_FALL || cap_edge[i] == GPT_EDGE_BOTH)
                && !cap_filt[i] && cap_prev_ff[i]);

        // Latch count on the selected edge
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                cap_prev_ff[i] <= 1'b0;
                cap_val_ff[i]  <= 16'h0000;
            end else begin
                cap_prev_ff[i] <= cap_filt[i];
                if (cap_evt[i]) begin
                    cap_val_ff[i] <= frc_ff; // [R11]
                end
            end
        end
    end

    // ************************************************************
    // Pulse accumulator
    // ************************************************************
    gpt_cond u_pa_cond (
        .clk     (clk),
        .reset_n (reset_n),
        .raw     (pa_pin_in),
        .filt    (pa_filt)
    );

    assign pa_act      = pa_active_high ? pa_filt : !pa_filt;
    assign pa_act_prev = pa_active_high ? pa_prev_ff : !pa_prev_ff;
    assign pa_lead     = pa_act && !pa_act_prev;
    assign pa_trail    = !pa_act && pa_act_prev;

    // Increment source per mode
    always_comb begin
        pa_inc = 1'b0;
        if (pa_enable) begin
            unique case (pa_mode)
                GPT_PA_EVENT:    pa_inc = pa_lead;        // [R2]
                GPT_PA_GATED:    pa_inc = pa_act && tick; // [R4]
                GPT_PA_OVF_GATE:
                    pa_inc = pa_act && count_overflow_event; // [R7]
                default:         pa_inc = 1'b0;
            endcase
        end
    end

    // Count register and edge history
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pa_prev_ff <= 1'b0;
            pa_cnt_ff  <= 8'h00;
        end else begin
            pa_prev_ff <= pa_filt;
            if (pa_inc) begin
                pa_cnt_ff <= pa_cnt_ff + 8'h01;
            end
        end
    end

    // ************************************************************
    // Output compare
    // ************************************************************
    assign cmp_hit = cnt_new_ff && (frc_ff == cmp_value);

    // Flag on the match, pin one clock later
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cmp_hit_d_ff <= 1'b0;
            cmp_act_ff   <= GPT_ACT_NONE;
            cmp_pin_ff   <= 1'b0;
        end else begin
            cmp_hit_d_ff <= cmp_hit;
            if (cmp_hit) begin
                cmp_act_ff <= cmp_action;
            end
            if (cmp_hit_d_ff) begin // [R10]
                unique case (cmp_act_ff)
                    GPT_ACT_NONE:   cmp_pin_ff <= cmp_pin_ff;
                    GPT_ACT_TOGGLE: cmp_pin_ff <= !cmp_pin_ff;
                    GPT_ACT_CLEAR:  cmp_pin_ff <= 1'b0;
                    GPT_ACT_SET:    cmp_pin_ff <= 1'b1;
                endcase
            end
        end
    end

    // ************************************************************
    // PWM channels
    // ************************************************************
    for (genvar j = 0; j < `GPT_NPWM; j++) begin : g_pwm
        // Counter, clear on duty match, else set on rollover
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                pwm_cnt_ff[j] <= 8'h00;
                pwm_pin_ff[j] <= 1'b0;
            end else if (tick) begin
                pwm_cnt_ff[j] <= pwm_cnt_ff[j] + 8'h01;
                if (pwm_cnt_ff[j] + 8'h01 == pwm_duty[j]) begin
                    pwm_pin_ff[j] <= 1'b0; // [R9]
                end else if (pwm_cnt_ff[j] == `GPT_PWM_MAX) begin
                    pwm_pin_ff[j] <= 1'b1; // [R8]
                end
            end
        end
    end

    // ************************************************************
    // Sticky flags
    // ************************************************************
    assign flag_set.cap  = cap_evt;                                 // [R11]
    assign flag_set.cmp  = cmp_hit;                                 // [R10]
    assign flag_set.pulse_input_flag = pa_enable &&
        ((pa_mode == GPT_PA_EVENT && pa_lead) ||
         (pa_mode == GPT_PA_GATED && pa_trail));                    // [R2] [R5]
    assign flag_set.paov = pa_inc && (pa_cnt_ff == `GPT_PA_MAX);   // [R3]

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= flag_set | (flags_ff & ~flag_clear); // [R14]
        end
    end

    // Output wiring, all from flops
    assign cap_pin_out        = gpo_ff.lvl;
    assign cap_pin_oe         = gpo_ff.oe;
    assign cap_value          = cap_val_ff;
    assign pulse_count        = pa_cnt_ff;
    assign cmp_pin            = cmp_pin_ff;
    assign pwm_pin            = pwm_pin_ff;
    assign free_running_count = frc_ff;
    assign flags              = flags_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_quiet3;
        !tick [*3];
    endsequence
    property p_tick_period;
        tick |=> s_quiet3 ##1 tick;
    endproperty
    a_tick_period: assert property (p_tick_period) // [R6]
        else $error("prescaler tick not every fourth clock");

    property p_frc_step;
        tick |=> frc_ff == 16'($past(frc_ff) + 16'h0001);
    endproperty
    a_frc_step: assert property (p_frc_step) // [R6]
        else $error("free-running count did not advance on tick");

    property p_cond_hold;
        cap_raw[0] [*5] |-> cap_filt[0];
    endproperty
    a_cond_hold: assert property (p_cond_hold) // [R1] [R12]
        else $error("steady capture level not conditioned");

    property p_pa_event;
        pa_enable && pa_mode == GPT_PA_EVENT && pa_lead |=>
            pa_cnt_ff == 8'($past(pa_cnt_ff) + 8'h01) &&
            flags_ff.pulse_input_flag;
    endproperty
    a_pa_event: assert property (p_pa_event) // [R2]
        else $error("event edge not counted or flagged");

    property p_pa_ovf;
        pa_inc && pa_cnt_ff == `GPT_PA_MAX |=>
            pa_cnt_ff == 8'h00 && flags_ff.paov;
    endproperty
    a_pa_ovf: assert property (p_pa_ovf) // [R3]
        else $error("pulse count wrap without overflow flag");

    property p_pa_gated;
        pa_enable && pa_mode == GPT_PA_GATED && pa_act && tick |=>
            pa_cnt_ff == 8'($past(pa_cnt_ff) + 8'h01);
    endproperty
    a_pa_gated: assert property (p_pa_gated) // [R4]
        else $error("gated count did not advance");

    property p_pa_gate_end;
        pa_enable && pa_mode == GPT_PA_GATED && pa_trail |=>
            flags_ff.pulse_input_flag;
    endproperty
    a_pa_gate_end: assert property (p_pa_gate_end) // [R5]
        else $error("gate end not flagged");

    property p_pa_ovf_gate;
        pa_enable && pa_mode == GPT_PA_OVF_GATE |=>
            pa_cnt_ff == 8'($past(pa_cnt_ff) +
                            8'($past(pa_act && count_overflow_event)));
    endproperty
    a_pa_ovf_gate: assert property (p_pa_ovf_gate) // [R7]
        else $error("overflow-gated count not tied to wrap");

    property p_pwm_set;
        tick && pwm_cnt_ff[0] == `GPT_PWM_MAX && pwm_duty[0] != 8'h00
            |=> pwm_pin_ff[0];
    endproperty
    a_pwm_set: assert property (p_pwm_set) // [R8]
        else $error("PWM pin not set on rollover");

    property p_pwm_clr;
        tick && 8'(pwm_cnt_ff[0] + 8'h01) == pwm_duty[0] |=> !pwm_pin_ff[0];
    endproperty
    a_pwm_clr: assert property (p_pwm_clr) // [R9]
        else $error("PWM pin not cleared on duty match");

    sequence s_cmp_toggle_hit;
        cmp_hit && cmp_action == GPT_ACT_TOGGLE;
    endsequence
    property p_cmp_toggle;
        s_cmp_toggle_hit |=> flags_ff.cmp && $stable(cmp_pin_ff)
            ##1 cmp_pin_ff != $past(cmp_pin_ff);
    endproperty
    a_cmp_toggle: assert property (p_cmp_toggle) // [R10]
        else $error("compare flag or pin toggle out of order");

    property p_cap_latch;
        cap_evt[0] |=> cap_val_ff[0] == $past(frc_ff) && flags_ff.cap[0];
    endproperty
    a_cap_latch: assert property (p_cap_latch) // [R11]
        else $error("capture value or flag wrong");

    property p_flag_sticky;
        flags_ff.pulse_input_flag && !flag_clear.pulse_input_flag |=>
            flags_ff.pulse_input_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // [R14]
        else $error("flag dropped without a clear");
endmodule : gpt_timer

// ===== src/gpt_params.svh
// Constants for the general-purpose timer and pulse accumulator
`ifndef GPT_PARAMS_SVH
`define GPT_PARAMS_SVH
`define GPT_CLK_MHZ       25
`define GPT_PRESCALE      4
`define GPT_PRE_LAST      2'h3
`define GPT_NCAP          2
`define GPT_NPWM          2
`define GPT_CNT_W         16
`define GPT_PA_W          8
`define GPT_PWM_W         8
`define GPT_CNT_MAX       16'hFFFF
`define GPT_PA_MAX        8'hFF
`define GPT_PWM_MAX       8'hFF
`define GPT_MIN_PULSE_CYC 2
`endif

// ===== src/gpt_pkg.sv
// Types shared by the general-purpose timer
`include "gpt_params.svh"
package gpt_pkg;
    // Pulse accumulator modes
    typedef enum logic [1:0] {
        GPT_PA_EVENT    = 2'h0,
        GPT_PA_GATED    = 2'h1,
        GPT_PA_OVF_GATE = 2'h3
    } gpt_pa_mode_e;
    // Capture edge selection
    typedef enum logic [1:0] {
        GPT_EDGE_OFF  = 2'h0,
        GPT_EDGE_RISE = 2'h1,
        GPT_EDGE_FALL = 2'h2,
        GPT_EDGE_BOTH = 2'h3
    } gpt_edge_e;
    // Compare pin actions
    typedef enum logic [1:0] {
        GPT_ACT_NONE   = 2'h0,
        GPT_ACT_TOGGLE = 2'h1,
        GPT_ACT_CLEAR  = 2'h2,
        GPT_ACT_SET    = 2'h3
    } gpt_oc_act_e;
    // Sticky status flags, also used for clear strobes
    typedef struct packed {
        logic [`GPT_NCAP-1:0] cap;
        logic                 cmp;
        logic                 pulse_input_flag;
        logic                 paov;
    } gpt_flags_s;
    // General-purpose drive of the capture pins
    typedef struct packed {
        logic [`GPT_NCAP-1:0] oe;
        logic [`GPT_NCAP-1:0] lvl;
    } gpt_gpo_s;
endpackage : gpt_pkg

// ===== testbench/gpt_pin_model.sv
// External pin model for the timer's capture and accumulator inputs
`timescale 1ns/1ps
`include "gpt_params.svh"

// ****************************************************************
// Pin model: external sources and two-way pin resolution
// ****************************************************************
module gpt_pin_model (
    // Levels the external sources want on the pins
    input  wire logic [`GPT_NCAP-1:0] cap_src,
    input  wire logic                 pa_src,
    // Device drive of the capture pins
    input  wire logic [`GPT_NCAP-1:0] cap_out,
    input  wire logic [`GPT_NCAP-1:0] cap_oe,
    // Resolved pin levels seen by the device
    output logic      [`GPT_NCAP-1:0] cap_pin,
    output logic                      pa_pin
);
    // Device drive wins where enabled, the source elsewhere
    assign cap_pin = (cap_oe & cap_out) | (~cap_oe & cap_src);
    // Accumulator pin is input only; widths set by the bench
    assign pa_pin  = pa_src;
endmodule : gpt_pin_model

// ===== testbench/gp_timer_pulse_accumulator_bench.sv
// Self-checking bench for the general-purpose timer
`timescale 1ns/1ps
`include "gpt_params.svh"

// ****************************************************************
// Bench top
// ****************************************************************
module gp_timer_pulse_accumulator_bench
    import gpt_pkg::*;
;
    logic                        clk = 1'h0;
    logic                        reset_n = 1'h0;
    logic [1:0]                  cap_src = 2'h0;
    logic                        pa_src = 1'h0;
    logic [1:0]                  cap_pin_in, cap_pin_out, cap_pin_oe;
    logic                        pa_pin_in, cmp_pin;
    gpt_gpo_s                    gpo_req = '0;
    gpt_edge_e [`GPT_NCAP-1:0]   cap_edge;
    logic [1:0][15:0]            cap_value;
    logic                        pa_enable = 1'h0;
    logic                        pa_active_high = 1'h1;
    gpt_pa_mode_e                pa_mode = GPT_PA_EVENT;
    logic [7:0]                  pulse_count;
    logic [15:0]                 cmp_value = 16'h8000;
    gpt_oc_act_e                 cmp_action = GPT_ACT_NONE;
    logic [1:0][7:0]             pwm_duty = {8'h00, 8'h40};
    logic [1:0]                  pwm_pin;
    logic [15:0]                 free_running_count;
    gpt_flags_s                  flag_clear = '0;
    gpt_flags_s                  flags;
    logic [4:0]                  fv;
    int                          fail_count = 0;
    int                          n_checks = 0;
    int                          cycles = 0;

    assign fv = flags;
    // Clock at 25 MHz
    always #20 clk = ~clk;

    gpt_pin_model u_pins (.cap_src(cap_src), .pa_src(pa_src),
        .cap_out(cap_pin_out), .cap_oe(cap_pin_oe),
        .cap_pin(cap_pin_in), .pa_pin(pa_pin_in));

    gpt_timer u_dut (.clk(clk), .reset_n(reset_n),
        .cap_pin_in(cap_pin_in), .cap_pin_out(cap_pin_out),
        .cap_pin_oe(cap_pin_oe), .gpo_req(gpo_req),
        .cap_edge(cap_edge), .cap_value(cap_value),
        .pa_pin_in(pa_pin_in), .pa_enable(pa_enable),
        .pa_active_high(pa_active_high), .pa_mode(pa_mode),
        .pulse_count(pulse_count), .cmp_value(cmp_value),
        .cmp_action(cmp_action), .cmp_pin(cmp_pin),
        .pwm_duty(pwm_duty), .pwm_pin(pwm_pin),
        .free_running_count(free_running_count),
        .flag_clear(flag_clear), .flags(flags));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wait_flag(input int b, output int i);
        for (i = 0; i < 40 && fv[b] !== 1'h1; i++) step(1);
    endtask : wait_flag

    task automatic clr(input logic [4:0] m);
        flag_clear = gpt_flags_s'(m);
        step(1);
        flag_clear = '0;
    endtask : clr

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_counter();
        logic [15:0] a;
        check("reset flags", fv, 5'h00);
        a = free_running_count;
        step(8);
        check("count step", free_running_count, a + 16'h0002);
        $display("done counter");
    endtask : t_counter

    task automatic t_capture();
        int i;
        cap_edge[0] = GPT_EDGE_RISE;
        cap_edge[1] = GPT_EDGE_RISE;
        cap_src = 2'h2;
        step(1);
        cap_src = 2'h1;
        wait_flag(3, i);
        check("cap delay", i >= 4, 1'h1);
        check("cap value", (cap_value[0] === free_running_count) ||
            (cap_value[0] === free_running_count - 16'h0001), 1'h1);
        step(8);
        check("glitch flag", fv[4], 1'h0);
        check("cap sticky", fv[3], 1'h1);
        clr(5'h08);
        check("cap cleared", fv[3], 1'h0);
        gpo_req.oe = 2'h2;
        gpo_req.lvl = 2'h2;
        wait_flag(4, i);
        check("gpo oe", cap_pin_oe, 2'h2);
        check("gpo capture", fv[4], 1'h1);
        check("gpo level", cap_pin_out, 2'h2);
        check("cap1 value", (cap_value[1] === free_running_count) ||
            (cap_value[1] === free_running_count - 16'h0001), 1'h1);
        clr(5'h18);
        cap_edge[0] = GPT_EDGE_FALL;
        cap_edge[1] = GPT_EDGE_BOTH;
        gpo_req = '0;
        cap_src = 2'h0;
        step(8);
        check("fall capture", fv[4:3], 2'h3);
        clr(5'h18);
        $display("done capture");
    endtask : t_capture

    task automatic t_accum();
        logic [7:0] n;
        pa_enable = 1'h1;
        n = pulse_count;
        repeat (3) begin
            pa_src = 1'h1;
            step(3);
            pa_src = 1'h0;
            step(3);
        end
        step(6);
        check("event count", pulse_count, 8'(n + 8'h03));
        check("event flag", fv[1], 1'h1);
        clr(5'h02);
        pa_mode = GPT_PA_GATED;
        n = pulse_count;
        pa_src = 1'h1;
        step(40);
        check("gate open flag", fv[1], 1'h0);
        pa_src = 1'h0;
        step(8);
        check("gated count", pulse_count, 8'(n + 8'h0a));
        check("gate end flag", fv[1], 1'h1);
        check("no overflow", fv[0], 1'h0);
        n = pulse_count;
        pa_src = 1'h1;
        step(1032);
        pa_src = 1'h0;
        step(8);
        check("wrap count", pulse_count, 8'(n + 8'h02));
        check("overflow flag", fv[0], 1'h1);
        pa_mode = GPT_PA_OVF_GATE;
        n = pulse_count;
        pa_src = 1'h1;
        step(200);
        pa_src = 1'h0;
        step(8);
        check("ovf gate no wrap", pulse_count, n);
        check("overflow sticky", fv[0], 1'h1);
        pa_mode = GPT_PA_EVENT;
        pa_active_high = 1'h0;
        n = pulse_count;
        pa_src = 1'h1;
        step(3);
        pa_src = 1'h0;
        step(6);
        check("active-low edge", pulse_count, 8'(n + 8'h01));
        pa_active_high = 1'h1;
        clr(5'h03);
        $display("done accumulator");
    endtask : t_accum

    task automatic t_pwm();
        int h0;
        int h1;
        h0 = 0;
        h1 = 0;
        repeat (1024) begin
            step(1);
            h0 += (pwm_pin[0] === 1'h1);
            h1 += (pwm_pin[1] === 1'h1);
        end
        check("pwm0 high", 16'(h0), 16'h0100);
        check("pwm1 high", 16'(h1), 16'h0000);
        $display("done pwm");
    endtask : t_pwm

    task automatic t_compare();
        gpt_oc_act_e acts[4];
        logic        p;
        logic        e;
        int          i;
        acts = '{GPT_ACT_SET, GPT_ACT_CLEAR, GPT_ACT_TOGGLE, GPT_ACT_NONE};
        clr(5'h04);
        foreach (acts[k]) begin
            cmp_action = acts[k];
            p = cmp_pin;
            cmp_value = free_running_count + 16'h0003;
            wait_flag(2, i);
            check("cmp flag", fv[2], 1'h1);
            check("pin after flag", cmp_pin, p);
            step(2);
            case (acts[k])
                GPT_ACT_SET:    e = 1'h1;
                GPT_ACT_CLEAR:  e = 1'h0;
                GPT_ACT_TOGGLE: e = ~p;
                default:        e = p;
            endcase
            check("pin action", cmp_pin, e);
            clr(5'h04);
        end
        $display("done compare");
    endtask : t_compare

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            final_report();
        end
    end

    // Main sequence
    initial begin
        cap_edge[0] = GPT_EDGE_OFF;
        cap_edge[1] = GPT_EDGE_OFF;
        step(12);
        reset_n = 1'h1;
        step(1);
        t_counter();
        t_capture();
        t_accum();
        t_pwm();
        t_compare();
        final_report();
    end
endmodule : gp_timer_pulse_accumulator_bench
